// *** pkg/sbet_pkg.sv ***
// Purpose: Shared constants and types for the 16-bit event timer
// Assumes: Classic Wishbone register access, 32-bit data words
// Notes: Register byte offsets are word aligned
package sbet_pkg;

    localparam int CNT_W = 16;
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_PRESC = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_CMP_PRI = 8'h0C;
    localparam logic [7:0] OFS_CMP_SEC = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    localparam int MODE_OVF_BIT = 0;
    localparam int MODE_INV_BIT = 1;
    localparam int MODE_RUN_LO = 2;
    localparam int MODE_RUN_HI = 3;
    localparam int PRESC_ES_LO = 4;
    localparam int PRESC_ES_HI = 5;

    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] PRESC_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam int IRQ_PRI = 0;
    localparam int IRQ_SEC = 1;
    localparam int IRQ_OVF = 2;

    typedef enum logic [1:0] {
        SBET_RUN_STOP = 2'b00,
        SBET_RUN_FREE = 2'b01,
        SBET_RUN_EDGE = 2'b10,
        SBET_RUN_MATCH = 2'b11
    } sbet_run_t;

    typedef enum logic [1:0] {
        SBET_EDGE_FALL = 2'b00,
        SBET_EDGE_RISE = 2'b01,
        SBET_EDGE_NONE = 2'b10,
        SBET_EDGE_BOTH = 2'b11
    } sbet_edge_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } sbet_wb_req_t;

endpackage

// *** rtl/sbet_edge_det.sv ***
// Purpose: Valid edge detector for the event input pin
// Assumes: Pin input synchronous to clk_i
// Notes: Output pulse is one cycle wide
`timescale 1ns/10ps
`default_nettype none
module sbet_edge_det
    import sbet_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire sbet_pkg::sbet_edge_t sel_i,
    output logic edge_o
);
    import sbet_pkg::*;

    logic prev_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= pin_i;
        end
    end

    // Edge choice per prescaler bits 5:4
    always_comb begin
        case (sel_i)
            SBET_EDGE_FALL: edge_o = prev_q & ~pin_i;
            SBET_EDGE_RISE: edge_o = ~prev_q & pin_i;
            SBET_EDGE_BOTH: edge_o = prev_q ^ pin_i;
            default: edge_o = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// *** rtl/sbet_timer.sv ***
// Purpose: 16-bit timer and external event counter with Wishbone registers
// Assumes: Classic Wishbone slave, one clock, event pin synchronous
// Notes: Counts one per valid pin edge, or every cycle when the edge select is none
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module sbet_timer
    import sbet_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sbet_pkg::sbet_wb_req_t wb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic event_input_pin_i,
    output logic primary_match_irq_o,
    output logic secondary_match_irq_o,
    output logic irq_o
);
    import sbet_pkg::*;

    logic [7:0] mode_q;
    logic [7:0] presc_q;
    logic [W-1:0] count_q;
    logic [W-1:0] cmp_pri_q;
    logic [W-1:0] cmp_sec_q;
    logic [2:0] stat_q;
    logic [2:0] mask_q;
    logic ev_edge;
    logic tick;
    logic wrap;
    logic pri_hit;
    logic sec_hit;
    logic clr_cnt;
    logic wr_acc;
    logic valid_adr;
    sbet_run_t run;
    sbet_edge_t esel;

    assign run = sbet_run_t'(mode_q[MODE_RUN_HI:MODE_RUN_LO]);
    assign esel = sbet_edge_t'(presc_q[PRESC_ES_HI:PRESC_ES_LO]);

    ////////////////////////////////////////////////////////////////////////
    // Event edge detection
    sbet_edge_det u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(event_input_pin_i),
        .sel_i(esel),
        .edge_o(ev_edge)
    );

    ////////////////////////////////////////////////////////////////////////
    // Counter
    // Edge select none means internal clock counting
    assign tick = (run != SBET_RUN_STOP) && ((esel == SBET_EDGE_NONE) || ev_edge);
    assign wrap = tick && (count_q == COUNT_MAX[W-1:0]);
    assign pri_hit = tick && (count_q == cmp_pri_q);
    assign sec_hit = tick && (count_q == cmp_sec_q);
    assign clr_cnt = ((run == SBET_RUN_EDGE) && ev_edge)
        || ((run == SBET_RUN_MATCH) && pri_hit);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= COUNT_ZERO[W-1:0];
        end else if (run == SBET_RUN_STOP) begin
            count_q <= COUNT_ZERO[W-1:0];
        end else if (clr_cnt) begin
            count_q <= COUNT_ZERO[W-1:0];
        end else if (tick) begin
            count_q <= count_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone register access
    assign wr_acc = wb_i.cyc && wb_i.stb && wb_i.we && !wb_ack_o && !wb_err_o;
    always_comb begin
        case (wb_i.adr)
            OFS_MODE, OFS_PRESC, OFS_COUNT, OFS_CMP_PRI,
            OFS_CMP_SEC, OFS_IRQ_STAT, OFS_IRQ_MASK: valid_adr = 1'b1;
            default: valid_adr = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= MODE_RESET;
        end else begin
            if (wr_acc && wb_i.adr == OFS_MODE && wb_i.sel[0]) begin
                mode_q[MODE_RUN_HI:MODE_INV_BIT] <= wb_i.dat[MODE_RUN_HI:MODE_INV_BIT];
                // Written one sets, written zero clears; hardware wrap wins unless the write selects the stop run mode
                mode_q[MODE_OVF_BIT] <= wb_i.dat[MODE_OVF_BIT] || wrap;
                if (wb_i.dat[MODE_RUN_HI:MODE_RUN_LO] == SBET_RUN_STOP) begin
                    mode_q[MODE_OVF_BIT] <= wb_i.dat[MODE_OVF_BIT];
                end
            end else if (wrap) begin
                mode_q[MODE_OVF_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc_q <= PRESC_RESET;
            cmp_pri_q <= CMP_RESET[W-1:0];
            cmp_sec_q <= CMP_RESET[W-1:0];
            mask_q <= IRQ_RESET;
        end else if (wr_acc) begin
            if (wb_i.adr == OFS_PRESC && wb_i.sel[0]) begin
                presc_q <= wb_i.dat[7:0];
            end
            if (wb_i.adr == OFS_CMP_PRI && wb_i.sel[0]) begin
                cmp_pri_q[7:0] <= wb_i.dat[7:0];
            end
            if (wb_i.adr == OFS_CMP_PRI && wb_i.sel[1]) begin
                cmp_pri_q[W-1:8] <= wb_i.dat[W-1:8];
            end
            if (wb_i.adr == OFS_CMP_SEC && wb_i.sel[0]) begin
                cmp_sec_q[7:0] <= wb_i.dat[7:0];
            end
            if (wb_i.adr == OFS_CMP_SEC && wb_i.sel[1]) begin
                cmp_sec_q[W-1:8] <= wb_i.dat[W-1:8];
            end
            if (wb_i.adr == OFS_IRQ_MASK && wb_i.sel[0]) begin
                mask_q <= wb_i.dat[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status, write one to clear, set wins
    logic [2:0] ev_set;
    logic [2:0] w1c;
    assign ev_set = {wrap, sec_hit, pri_hit};
    assign w1c = (wr_acc && wb_i.adr == OFS_IRQ_STAT && wb_i.sel[0]) ? wb_i.dat[2:0] : 3'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= IRQ_RESET;
            irq_o <= 1'b0;
            primary_match_irq_o <= 1'b0;
            secondary_match_irq_o <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~w1c) | ev_set;
            irq_o <= |(((stat_q & ~w1c) | ev_set) & mask_q);
            primary_match_irq_o <= pri_hit;
            secondary_match_irq_o <= sec_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and ack, one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_i.cyc && wb_i.stb && !wb_ack_o && !wb_err_o && valid_adr;
            wb_err_o <= wb_i.cyc && wb_i.stb && !wb_ack_o && !wb_err_o && !valid_adr;
            case (wb_i.adr)
                OFS_MODE: wb_dat_o <= {24'h00_0000, mode_q};
                OFS_PRESC: wb_dat_o <= {24'h00_0000, presc_q};
                OFS_COUNT: wb_dat_o <= {{(32-W){1'b0}}, count_q};
                OFS_CMP_PRI: wb_dat_o <= {{(32-W){1'b0}}, cmp_pri_q};
                OFS_CMP_SEC: wb_dat_o <= {{(32-W){1'b0}}, cmp_sec_q};
                OFS_IRQ_STAT: wb_dat_o <= {29'h0000_0000, stat_q};
                OFS_IRQ_MASK: wb_dat_o <= {29'h0000_0000, mask_q};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_ovf_on_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        (wrap && !(wr_acc && wb_i.adr == OFS_MODE && wb_i.sel[0]
        && wb_i.dat[MODE_RUN_HI:MODE_RUN_LO] == SBET_RUN_STOP))
        |=> mode_q[MODE_OVF_BIT]) else $error("overflow flag not set on wrap");
    a_ovf_sw_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_acc && wb_i.adr == OFS_MODE && wb_i.sel[0] && wb_i.dat[0])
        |=> mode_q[MODE_OVF_BIT]) else $error("software set of overflow lost");
    a_ovf_stop_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_acc && wb_i.adr == OFS_MODE && wb_i.sel[0] && wb_i.dat[3:0] == 4'h0)
        |=> !mode_q[MODE_OVF_BIT]) else $error("overflow flag not cleared");
    a_edge_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (run == SBET_RUN_FREE && esel == SBET_EDGE_RISE && !ev_edge)
        |=> count_q == $past(count_q)) else $error("count moved without edge");
    a_pri_match: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && count_q == cmp_pri_q) |=> primary_match_irq_o)
        else $error("primary match missed");
    a_sec_match: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && count_q == cmp_sec_q) |=> secondary_match_irq_o)
        else $error("secondary match missed");
    a_count_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_i.cyc && wb_i.stb && !wb_i.we && wb_i.adr == OFS_COUNT && !wb_ack_o && !wb_err_o)
        |=> wb_ack_o && wb_dat_o[W-1:0] == $past(count_q)) else $error("count read wrong");
    a_stop_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (run == SBET_RUN_STOP) |=> count_q == COUNT_ZERO[W-1:0])
        else $error("stopped counter not cleared");
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 irq_o == |($past(stat_q & ~w1c | ev_set) & $past(mask_q)))
        else $error("interrupt level wrong");
endmodule
`default_nettype wire

// *** verif/sbet_event_src.sv ***
// Purpose: External event source that drives the timer input pin
// Assumes: Pulses are synchronous to clk_i
// Notes: Slow mode stretches the low time of each pulse
`timescale 1ns/10ps
`default_nettype none
module sbet_event_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic slow_i,
    input wire logic [15:0] n_i,
    output logic pin_o,
    output logic busy_o
);
    logic [15:0] left_q;
    logic [2:0] ph_q;
    ////////////////////////////////////////////////////////////////
    // One pulse: two cycles high, then two or six cycles low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_q <= '0;
            ph_q <= '0;
            pin_o <= 1'b0;
        end else if (start_i) begin
            left_q <= n_i;
            ph_q <= '0;
        end else if (left_q != 16'h0) begin
            ph_q <= ph_q + 3'h1;
            if (ph_q == 3'h0) pin_o <= 1'b1;
            if (ph_q == 3'h2) pin_o <= 1'b0;
            if (ph_q == (slow_i ? 3'h7 : 3'h3)) begin
                ph_q <= '0;
                left_q <= left_q - 16'h1;
            end
        end
    end
    assign busy_o = (left_q != 16'h0);
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the event timer
// Assumes: Event source model drives the pin
// Notes: The overflow run takes about 66k cycles
`timescale 1ns/10ps
`default_nettype none
module tb;
    import sbet_pkg::*;
    logic clk_i = 0;
    logic rst_i = 1;
    sbet_wb_req_t wb_q = '0;
    logic [31:0] wb_dat_o, rdat;
    logic wb_ack_o, wb_err_o, pin, irq_o, busy, rerr;
    logic pri_irq, sec_irq;
    logic start_q = 0;
    logic slow_q = 0;
    logic [15:0] n_q = 0;
    int n_mismatch = 0;
    int cmp_count = 0;
    int m, s, k;
    int n_pri = 0;
    int n_sec = 0;
    int p0, s0;
    int codes[3] = '{0, 1, 3};
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    sbet_timer #(.W(CNT_W)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_q),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .event_input_pin_i(pin), .primary_match_irq_o(pri_irq),
        .secondary_match_irq_o(sec_irq), .irq_o(irq_o));
    sbet_event_src SRC (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_q), .slow_i(slow_q),
        .n_i(n_q), .pin_o(pin), .busy_o(busy));
    // Counts match pulses seen on the pins
    always @(posedge clk_i) begin
        if (pri_irq === 1'b1) n_pri++;
        if (sec_irq === 1'b1) n_sec++;
    end
    ////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("wrong value %s exp %h got %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic timeout;
        n_mismatch++;
        print_verdict();
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int i;
        wb_q <= '{1'b1, 1'b1, we, 4'hF, a, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
        end
        if (i == 20) timeout();
        rdat = wb_dat_o;
        rerr = wb_err_o;
        wb_q <= '0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask
    task automatic send(input logic [15:0] n);
        int i;
        slow_q <= 1'($urandom % 2);
        n_q <= n;
        start_q <= 1'b1;
        @(posedge clk_i);
        start_q <= 1'b0;
        for (i = 0; i < 1000; i++) begin
            @(posedge clk_i);
            if (busy === 1'b0) break;
        end
        if (i == 1000) timeout();
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hc7b1_d4ef));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 0; k < 7; k++) rd(8'(4 * k), 32'h0, "reset value");
        rd(8'h1C, 32'h0, "unmapped data");
        chk("unmapped err", 32'h1, {31'h0, rerr});
        m = 2 + $urandom % 20;
        s = 1 + $urandom % (m - 1);
        wb(1'b1, OFS_CMP_PRI, 32'(m));
        wb(1'b1, OFS_CMP_SEC, 32'(s));
        foreach (codes[j]) begin
            wb(1'b1, OFS_MODE, 32'h0);
            wb(1'b1, OFS_PRESC, 32'(codes[j] << 4));
            wb(1'b1, OFS_MODE, 32'h4);
            send(16'h5);
            rd(OFS_COUNT, (codes[j] == 3) ? 32'hA : 32'h5, "edge count");
            rd(OFS_COUNT, (codes[j] == 3) ? 32'hA : 32'h5, "count reread");
        end
        wb(1'b1, OFS_MODE, 32'h0);
        wb(1'b1, OFS_PRESC, 32'h10);
        wb(1'b1, OFS_IRQ_STAT, 32'h7);
        wb(1'b1, OFS_IRQ_MASK, 32'h1);
        wb(1'b1, OFS_MODE, 32'h4);
        p0 = n_pri;
        s0 = n_sec;
        send(16'(m));
        rd(OFS_IRQ_STAT, 32'h2, "status after M");
        chk("irq masked", 32'h0, {31'h0, irq_o});
        chk("primary pulse early", 32'h0, 32'(n_pri - p0));
        chk("secondary pulse", 32'h1, 32'(n_sec - s0));
        send(16'h1);
        rd(OFS_IRQ_STAT, 32'h3, "status after M+1");
        chk("irq primary", 32'h1, {31'h0, irq_o});
        chk("primary pulse", 32'h1, 32'(n_pri - p0));
        rd(OFS_COUNT, 32'(m + 1), "count M+1");
        wb(1'b1, OFS_IRQ_STAT, 32'h1);
        rd(OFS_IRQ_STAT, 32'h2, "status cleared");
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        wb(1'b1, OFS_IRQ_MASK, 32'h2);
        chk("irq secondary", 32'h1, {31'h0, irq_o});
        wb(1'b1, OFS_MODE, 32'h0);
        wb(1'b1, OFS_MODE, 32'hC);
        send(16'(m + 1));
        rd(OFS_COUNT, 32'h0, "match clear");
        send(16'h2);
        rd(OFS_COUNT, 32'h2, "after clear");
        wb(1'b1, OFS_MODE, 32'h0);
        rd(OFS_COUNT, 32'h0, "stop clears");
        wb(1'b1, OFS_MODE, 32'h8);
        send(16'h3);
        rd(OFS_COUNT, 32'h0, "edge clear");
        wb(1'b1, OFS_MODE, 32'h0);
        wb(1'b1, OFS_IRQ_STAT, 32'h7);
        wb(1'b1, OFS_IRQ_MASK, 32'h4);
        wb(1'b1, OFS_PRESC, 32'h20);
        wb(1'b1, OFS_MODE, 32'h4);
        for (k = 0; k < 70000; k++) begin
            @(posedge clk_i);
            if (irq_o === 1'b1) break;
        end
        if (k == 70000) timeout();
        rd(OFS_MODE, 32'h5, "overflow flag");
        rd(OFS_IRQ_STAT, 32'h7, "status wrap");
        wb(1'b1, OFS_MODE, 32'h4);
        rd(OFS_MODE, 32'h4, "flag write zero");
        wb(1'b1, OFS_MODE, 32'h5);
        rd(OFS_MODE, 32'h5, "flag write one");
        wb(1'b1, OFS_MODE, 32'h1);
        wb(1'b1, OFS_MODE, 32'h0);
        rd(OFS_MODE, 32'h0, "flag stop");
        print_verdict();
    end
endmodule
`default_nettype wire
